// file: hdl/tcc_regs.svh
// register offsets, field positions and reset values of the timer channel
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
`define TCC_ADDR_SC 2'h0
`define TCC_ADDR_VH 2'h1
`define TCC_ADDR_VL 2'h2
`define TCC_SC_FLAG 7
`define TCC_SC_IE 6
`define TCC_SC_MSB 5
`define TCC_SC_MSA 4
`define TCC_SC_ELS_HI 3
`define TCC_SC_ELS_LO 2
`define TCC_RST_VAL 16'h0000
`define TCC_RST_BYTE 8'h00
`define TCC_CNT_ZERO 16'h0000
`define TCC_SYNC_STAGES 2
`endif

// file: hdl/tcc_pkg.sv
// types shared by the timer channel and its bench
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_IC = 2'h0,
    TCC_OC = 2'h1,
    TCC_EPWM = 2'h3,
    TCC_CPWM = 2'h2
  } tcc_mode_e;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcc_bus_s;
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] modulus;
    logic tick;
    logic ovf;
    logic down;
    logic center;
  } tcc_core_s;
  typedef struct packed {
    logic flag;
    logic ie;
    logic ms_hi;
    logic ms_lo;
    logic [1:0] els;
    logic armed;
    logic [15:0] val;
    logic [15:0] buf_val;
    logic got_hi;
    logic got_lo;
    logic latched;
    logic hold_hi;
    logic [15:0] hold;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic out;
    logic oe;
    logic irq;
    logic [7:0] rdata;
  } tcc_state_s;
endpackage

// file: hdl/tcc_channel.sv
// one timer channel: capture, compare, edge and center pwm
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_channel (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input tcc_pkg::tcc_bus_s bus,
  output logic [7:0] rdata,
  // timer core
  input tcc_pkg::tcc_core_s core,
  // channel pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // interrupt request
  output logic channel_irq
);

  tcc_pkg::tcc_state_s q;
  tcc_pkg::tcc_state_s next_q;
  tcc_pkg::tcc_mode_e mode;
  logic match;
  logic rise;
  logic fall;
  logic ev;
  logic full;
  logic load;
  logic [15:0] cmp_val;

  always_comb
  begin
    if (core.center)
    begin
      mode = tcc_pkg::TCC_CPWM;
    end
    else if (q.ms_hi)
    begin
      mode = tcc_pkg::TCC_EPWM;
    end
    else if (q.ms_lo)
    begin
      mode = tcc_pkg::TCC_OC;
    end
    else
    begin
      mode = tcc_pkg::TCC_IC;
    end
  end

  // paired bytes that move this cycle already govern this count, so a
  // zero value loaded at counter zero gives 0% from its first period
  assign load = q.got_hi && q.got_lo && (mode == tcc_pkg::TCC_IC
    || mode == tcc_pkg::TCC_OC || core.cnt == `TCC_CNT_ZERO);
  assign cmp_val = load ? q.buf_val : q.val;
  // compared once per counter step only
  assign match = core.tick && (core.cnt == cmp_val);
  assign rise = q.pin_s2 & ~q.pin_prev;
  assign fall = ~q.pin_s2 & q.pin_prev;
  // value beyond modulus never matches: output stays at its
  // overflow level for the whole period
  assign full = cmp_val > core.modulus;

  always_comb
  begin
    if (mode == tcc_pkg::TCC_IC)
    begin
      // bit 0 picks rising, bit 1 falling; 00 disables capture
      ev = (q.els[0] & rise) | (q.els[1] & fall);
    end
    else
    begin
      ev = match;
    end
  end

  always_comb
  begin
    next_q = q;
    next_q.pin_s1 = pin_in;
    next_q.pin_s2 = q.pin_s1;
    next_q.pin_prev = q.pin_s2;
    next_q.rdata = `TCC_RST_BYTE;

    // buffered value moves to the active register
    if (q.got_hi && q.got_lo)
    begin
      if (mode == tcc_pkg::TCC_IC || mode == tcc_pkg::TCC_OC)
      begin
        next_q.val = q.buf_val;
        next_q.got_hi = 1'b0;
        next_q.got_lo = 1'b0;
      end
      else if (core.cnt == `TCC_CNT_ZERO)
      begin
        next_q.val = q.buf_val;
        next_q.got_hi = 1'b0;
        next_q.got_lo = 1'b0;
      end
    end

    if (bus.rd)
    begin
      case (bus.addr)
        `TCC_ADDR_SC:
        begin
          next_q.rdata = {q.flag, q.ie, q.ms_hi, q.ms_lo, q.els, 2'h0};
          if (q.flag)
          begin
            next_q.armed = 1'b1;
          end
        end
        `TCC_ADDR_VH, `TCC_ADDR_VL:
        begin
          if (mode == tcc_pkg::TCC_IC && q.latched)
          begin
            next_q.rdata = bus.addr[0] ? q.hold[15:8] : q.hold[7:0];
            // reading the other byte releases the latch
            if (q.hold_hi != bus.addr[0])
            begin
              next_q.latched = 1'b0;
            end
          end
          else
          begin
            next_q.rdata = bus.addr[0] ? q.val[15:8] : q.val[7:0];
            if (mode == tcc_pkg::TCC_IC)
            begin
              next_q.latched = 1'b1;
              next_q.hold = q.val;
              next_q.hold_hi = bus.addr[0];
            end
          end
        end
        default:
        begin
          next_q.rdata = `TCC_RST_BYTE;
        end
      endcase
    end

    if (bus.wr)
    begin
      case (bus.addr)
        `TCC_ADDR_SC:
        begin
          next_q.ie = bus.wdata[`TCC_SC_IE];
          next_q.ms_hi = bus.wdata[`TCC_SC_MSB];
          next_q.ms_lo = bus.wdata[`TCC_SC_MSA];
          next_q.els = bus.wdata[`TCC_SC_ELS_HI:`TCC_SC_ELS_LO];
          // writing one to the flag does nothing
          if (q.armed && !bus.wdata[`TCC_SC_FLAG])
          begin
            next_q.flag = 1'b0;
          end
          next_q.armed = 1'b0;
          next_q.latched = 1'b0;
          next_q.got_hi = 1'b0;
          next_q.got_lo = 1'b0;
        end
        `TCC_ADDR_VH:
        begin
          next_q.buf_val[15:8] = bus.wdata;
          next_q.got_hi = 1'b1;
        end
        `TCC_ADDR_VL:
        begin
          next_q.buf_val[7:0] = bus.wdata;
          next_q.got_lo = 1'b1;
        end
        default:
        begin
          next_q.ie = q.ie;
        end
      endcase
    end

    // event wins over a clear in the same cycle
    if (ev)
    begin
      next_q.flag = 1'b1;
      next_q.armed = 1'b0;
      if (mode == tcc_pkg::TCC_IC)
      begin
        next_q.val = core.cnt;
      end
    end

    // pin drive; released entirely when the select is 00
    next_q.oe = (q.els != 2'h0) && (mode != tcc_pkg::TCC_IC);
    case (mode)
      tcc_pkg::TCC_OC:
      begin
        if (match)
        begin
          case (q.els)
            2'h1: next_q.out = ~q.out;
            2'h2: next_q.out = 1'b0;
            2'h3: next_q.out = 1'b1;
            default: next_q.out = q.out;
          endcase
        end
      end
      tcc_pkg::TCC_EPWM:
      begin
        // match after overflow so a zero value gives 0% duty
        if (core.ovf && core.tick)
        begin
          next_q.out = ~q.els[0];
        end
        if (match && !full)
        begin
          next_q.out = q.els[0];
        end
      end
      tcc_pkg::TCC_CPWM:
      begin
        if (match)
        begin
          next_q.out = q.els[0] ^ core.down;
        end
      end
      default:
      begin
        next_q.out = q.out;
      end
    endcase

    next_q.irq = next_q.flag & next_q.ie;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;
  assign pin_out = q.out;
  assign pin_oe = q.oe;
  assign channel_irq = q.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_capture_sets_flag: assert property (
    mode == tcc_pkg::TCC_IC && q.els == 2'h1 && rise |=> q.flag)
    else $error("rising edge did not set the flag");

  a_capture_value: assert property (
    mode == tcc_pkg::TCC_IC && ev |=> q.val == $past(core.cnt))
    else $error("captured value differs from counter");

  a_rise_only: assert property (
    mode == tcc_pkg::TCC_IC && q.els == 2'h1 && fall && !q.flag
    && !bus.wr |=> !q.flag)
    else $error("falling edge captured in rising mode");

  a_compare_flag: assert property (
    mode == tcc_pkg::TCC_OC && match ##1 !bus.wr[*2] |-> q.flag)
    else $error("compare match did not set the flag");

  a_center_flag: assert property (
    mode == tcc_pkg::TCC_CPWM && match |=> q.flag)
    else $error("center match did not set the flag");

  a_irq_request: assert property (
    q.flag && q.ie && !bus.wr |=> channel_irq)
    else $error("interrupt not requested");

  a_write_one_keeps: assert property (
    q.flag && bus.wr && bus.addr == `TCC_ADDR_SC && bus.wdata[`TCC_SC_FLAG] |=> q.flag)
    else $error("writing one cleared the flag");

  a_clear_needs_read: assert property (
    q.flag && !q.armed && bus.wr && bus.addr == `TCC_ADDR_SC |=> q.flag)
    else $error("flag cleared without prior read");

  a_event_wins: assert property (
    ev |=> q.flag && !q.armed)
    else $error("event lost during clear");

  a_reset_zero: assert property (@(posedge clk_sys) disable iff (1'b0)
    rst |=> !q.flag && !q.ie && q.val == `TCC_RST_VAL)
    else $error("reset left state behind");

  a_pin_release: assert property (
    $past(q.els) == 2'h0 |-> !pin_oe)
    else $error("pin driven with select 00");

  a_oc_set: assert property (
    mode == tcc_pkg::TCC_OC && q.els == 2'h3 && match |=> pin_out)
    else $error("set on compare failed");

  a_pwm_overflow: assert property (
    mode == tcc_pkg::TCC_EPWM && !q.els[0] && core.ovf && core.tick
    && !match |=> pin_out)
    else $error("overflow did not raise pwm output");

  a_zero_duty: assert property (
    mode == tcc_pkg::TCC_EPWM && q.els == 2'h2 && q.val == 16'h0000
    && match |=> !pin_out)
    else $error("zero value gave a pulse");

  a_oc_pairing: assert property (
    mode == tcc_pkg::TCC_OC && q.got_hi && q.got_lo && !ev
    |=> q.val == $past(q.buf_val))
    else $error("paired bytes not loaded");

  a_pwm_load_zero: assert property (
    $past(mode) == tcc_pkg::TCC_EPWM && q.val != $past(q.val)
    |-> $past(core.cnt) == 16'h0000)
    else $error("pwm value loaded away from zero");

  a_latch_hold: assert property (
    mode == tcc_pkg::TCC_IC && q.latched && bus.rd && bus.addr == `TCC_ADDR_VL
    |=> rdata == $past(q.hold[7:0]))
    else $error("latched byte not returned");

  a_fall_capture: assert property (
    mode == tcc_pkg::TCC_IC && q.els == 2'h2 && fall |=> q.flag)
    else $error("falling edge did not set the flag");

  a_oc_toggle: assert property (
    mode == tcc_pkg::TCC_OC && q.els == 2'h1 && match |=> pin_out != $past(pin_out))
    else $error("toggle on compare failed");

  a_oc_clear: assert property (
    mode == tcc_pkg::TCC_OC && q.els == 2'h2 && match |=> !pin_out)
    else $error("clear on compare failed");

  a_epwm_low_true: assert property (
    mode == tcc_pkg::TCC_EPWM && q.els[0] && match && !full |=> pin_out)
    else $error("low-true pwm match did not set output");

  a_center_up_clear: assert property (
    mode == tcc_pkg::TCC_CPWM && q.els == 2'h2 && match && !core.down |=> !pin_out)
    else $error("center up match did not clear output");

  a_center_up_set: assert property (
    mode == tcc_pkg::TCC_CPWM && q.els[0] && match && !core.down |=> pin_out)
    else $error("center up match did not set output");

  c_capture: cover property (mode == tcc_pkg::TCC_IC && ev ##1 q.flag);
  c_clear: cover property (q.armed && bus.wr ##1 !q.flag);
  c_pwm_cycle: cover property (mode == tcc_pkg::TCC_EPWM && pin_out ##[1:50] !pin_out);
  c_center: cover property (mode == tcc_pkg::TCC_CPWM && match);

endmodule

// file: test/tcc_core_model.sv
// far-side model: shared counter of the timer core
`timescale 1ns/1ps
module tcc_core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bench control
  input wire logic run,
  input wire logic center,
  input wire logic [15:0] modulus,
  // to the channel
  output tcc_pkg::tcc_core_s core
);
  // edge mode wraps at the modulus; center mode turns there and at zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      core <= '0;
    end
    else
    begin
      core.tick <= run;
      core.modulus <= modulus;
      core.center <= center;
      core.ovf <= run && !center && (core.cnt >= modulus);
      if (run && !center)
      begin
        // >= so a lowered modulus cannot strand the count
        core.down <= 1'b0;
        core.cnt <= (core.cnt >= modulus) ? 16'h0000 : core.cnt + 16'h0001;
      end
      else if (run && core.down)
      begin
        core.down <= (core.cnt > 16'h0001);
        core.cnt <= core.cnt - 16'h0001;
      end
      else if (run)
      begin
        core.down <= (core.cnt + 16'h0001 >= modulus);
        core.cnt <= core.cnt + 16'h0001;
      end
    end
  end
endmodule

// file: test/timer_channel_capture_compare_pwm_tb.sv
// self-checking bench of one timer channel
`timescale 1ns/1ps
module timer_channel_capture_compare_pwm_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic center = 1'b0;
  logic pin_in = 1'b0;
  logic [15:0] modulus = 16'hFFFF;
  tcc_pkg::tcc_bus_s bus = '0;
  tcc_pkg::tcc_core_s core;
  logic [7:0] rdata;
  logic [15:0] cap;
  logic pin_out;
  logic pin_oe;
  logic channel_irq;
  int err_total = 0;
  int n_compared = 0;

  tcc_core_model u_tcc_core_model (.clk_sys(clk_sys), .rst(rst), .run(run),
    .center(center), .modulus(modulus), .core(core));
  tcc_channel u_tcc_channel (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .core(core), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .channel_irq(channel_irq));

  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
  begin
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  end
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
  begin
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  end
  endtask

  // returns at the falling edge before the channel sees count v
  task automatic wait_cnt(input logic [15:0] v);
  begin
    for (int i = 0; i < 100; i++)
    begin
      @(negedge clk_sys);
      if (core.tick && core.cnt === v)
      begin
        break;
      end
    end
  end
  endtask

  task automatic finish_test;
  begin
    if (err_total == 0 && n_compared > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  end
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    run <= 1'b1;
    repeat (37) @(posedge clk_sys);
    run <= 1'b0;
    // pin has been quiet since reset
    wr(2'h0, 8'h04);
    rd(2'h0, 8'h04);
    wr(2'h0, 8'h04);
    pin_in <= 1'b1;
    repeat (6) @(posedge clk_sys);
    cap = core.cnt;
    rd(2'h0, 8'h84);
    wr(2'h0, 8'h04);
    rd(2'h0, 8'h04);
    pin_in <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(2'h0, 8'h04);
    rd(2'h1, cap[15:8]);
    run <= 1'b1;
    repeat (5) @(posedge clk_sys);
    run <= 1'b0;
    pin_in <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(2'h2, cap[7:0]);
    cap = core.cnt;
    rd(2'h1, cap[15:8]);
    rd(2'h2, cap[7:0]);
    // toggle on compare, request enabled
    wr(2'h0, 8'h54);
    rd(2'h0, 8'hD4);
    wr(2'h0, 8'h54);
    wr(2'h1, cap[15:8]);
    wr(2'h2, cap[7:0] + 8'h03);
    run <= 1'b1;
    for (int i = 0; i < 20 && channel_irq !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk(channel_irq, 1'b1);
    chk(pin_out, 1'b1);
    chk(pin_oe, 1'b1);
    @(posedge clk_sys);
    run <= 1'b0;
    rd(2'h0, 8'hD4);
    wr(2'h0, 8'hD4);
    rd(2'h0, 8'hD4);
    wr(2'h0, 8'h54);
    rd(2'h0, 8'h54);
    chk(channel_irq, 1'b0);
    wr(2'h0, 8'h30);
    repeat (2) @(posedge clk_sys);
    #1 chk(pin_oe, 1'b0);
    modulus <= 16'h0010;
    run <= 1'b1;
    wr(2'h0, 8'h28);
    for (int p = 0; p < 2; p++)
    begin
      // a control write restarts byte pairing, so the value goes last
      wr(2'h0, p ? 8'h2C : 8'h28);
      wr(2'h1, 8'h00);
      wr(2'h2, 8'h08);
      wait_cnt(16'h0000);
      @(posedge clk_sys);
      #1 chk(pin_out, p == 0);
      wait_cnt(16'h0008);
      @(posedge clk_sys);
      #1 chk(pin_out, p != 0);
    end
    // 0% then 100% duty, judged at the end of a period
    for (int v = 0; v < 2; v++)
    begin
      wr(2'h0, 8'h28);
      wr(2'h1, 8'h00);
      wr(2'h2, v ? 8'h20 : 8'h00);
      wait_cnt(16'h0000);
      wait_cnt(16'h0010);
      @(posedge clk_sys);
      #1 chk(pin_out, v != 0);
    end
    // center mode: value 8 is met once counting up, once counting down
    center <= 1'b1;
    wr(2'h0, 8'h08);
    rd(2'h0, 8'h88);
    wr(2'h0, 8'h08);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h08);
    wait_cnt(16'h0000);
    wait_cnt(16'h0008);
    @(posedge clk_sys);
    #1 chk(pin_out, 1'b0);
    wait_cnt(16'h0008);
    @(posedge clk_sys);
    #1 chk(pin_out, 1'b1);
    rd(2'h0, 8'h88);
    finish_test();
  end

  initial
  begin
    repeat (4000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
endmodule
